// >>> hw/ccr_regs.sv
// Charger control registers 4 and 5 with forced input-limit detection.
// Assumes an 8-bit register port already decoded from the serial bus and
// analog status inputs synchronous to ref_clk.
//
// Notes on behaviour
// - Bit 7 drives gate pair B; locked to 0 when pair absent at start.
// - Bit 6 drives gate pair A; locked to 0 when pair absent at start.
// - Bit 5 picks 1.5 MHz or 750 kHz; reset value comes from strap.
// - Bit 4 turns status pin off; cleared by watchdog or reset.
// - Bit 3 turns off system short hiccup; cleared by reset only.
// - Bit 2 turns off reverse undervoltage hiccup; reset only.
// - Detect request accepted only while battery exceeds minimum system.
// - Detection stops switching, measures, then updates limit and clears request together.
// - Bit 0 enables input overcurrent protection, default 1, reset only.
// - Ship switch not fitted holds discharge overcurrent enable at 0.
// - Once fitted bit is 1, the locked bit becomes writable.
// - Discharge sense enable, default 0, cleared by watchdog or reset.
// - Discharge limit field picks 3A, 4A, 5A, off; default code 2.
// - Internal current limit enable, default 1, restored by watchdog.
// - External current limit enable, default 1, restored by reset only.
// - Master gate-off forces both gate enables to 0.
// - Discharge overcurrent enable, default 0.
`default_nettype none

module ccr_regs (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   // Register access port
   input  wire ccr_pkg::ccr_req_t req,
   output var  logic [7:0]        rdata,
   // Soft resets
   input  wire logic              reg_reset,
   input  wire logic              wdog_expire,
   // Board and analog status
   input  wire logic              config_strap_pin,
   input  wire logic              gate_pair_a_found,
   input  wire logic              gate_pair_b_found,
   input  wire logic              gate_drive_master_off,
   input  wire logic              batt_above_min_sys,
   input  wire logic              meas_done,
   input  wire logic [7:0]        meas_value,
   // Controls to the power stage
   output var  ccr_pkg::ccr_ctl_t ctl,
   output var  logic              switching_halt,
   output var  logic              meas_start,
   output var  logic              input_voltage_limit_we,
   output var  logic [7:0]        input_voltage_limit
);
   import ccr_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] r4;
      logic [7:0] r5;
      logic       strap;
      logic       a_ok;
      logic       b_ok;
      logic       started;
      ccr_state_t st;
      logic [7:0] rdata;
      ccr_ctl_t   ctl;
      logic       halt;
      logic       mstart;
      logic       vl_we;
      logic [7:0] vl;
   } ccr_s_t;

   ccr_s_t s_q;
   ccr_s_t s_d;

   // Restore masked bits to their reset value.
   function automatic logic [7:0] restore(input logic [7:0] cur,
                                          input logic [7:0] rst,
                                          input logic [7:0] mask);
      restore = (cur & ~mask) | (rst & mask);
   endfunction

   // Apply lock conditions to control 4.
   function automatic logic [7:0] lock4(input logic [7:0] v,
                                        input logic a_ok,
                                        input logic b_ok,
                                        input logic moff);
      lock4 = v;
      lock4[CCR_B_GATE_B] = v[CCR_B_GATE_B] & b_ok & ~moff;
      lock4[CCR_B_GATE_A] = v[CCR_B_GATE_A] & a_ok & ~moff;
   endfunction

   // Apply lock conditions to control 5.
   function automatic logic [7:0] lock5(input logic [7:0] v);
      lock5 = v;
      lock5[CCR_B_RSVD] = 1'b0;
      if (!v[CCR_B_SHIP_FIT]) begin
         lock5 = lock5 & ~CCR_SHIP_LOCK;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [7:0] rst4;
      rst4 = CCR_RST_GATE_FREQ;
      s_d = s_q;
      s_d.mstart = 1'b0;
      s_d.vl_we = 1'b0;
      // Capture strap and gate-pair presence once after reset release.
      if (!s_q.started) begin
         s_d.started = 1'b1;
         s_d.strap = config_strap_pin;
         s_d.a_ok = gate_pair_a_found;
         s_d.b_ok = gate_pair_b_found;
         s_d.r4[CCR_B_SW_RATE] = config_strap_pin;
      end
      // Use the strap seen this cycle, so an early soft reset keeps it.
      rst4[CCR_B_SW_RATE] = s_d.strap;
      // Host write.
      if (req.wr && req.addr == CCR_OFS_GATE_FREQ) begin
         s_d.r4 = req.wdata;
         // Detect request may be set only with battery above minimum.
         s_d.r4[CCR_B_VLIM_DET] = s_q.r4[CCR_B_VLIM_DET] |
            (req.wdata[CCR_B_VLIM_DET] & batt_above_min_sys);
      end
      if (req.wr && req.addr == CCR_OFS_SHIP_DSCH) begin
         s_d.r5 = req.wdata;
      end
      // Detection sequencer.
      case (s_q.st)
         CCR_ST_IDLE: begin
            if (s_d.r4[CCR_B_VLIM_DET]) begin
               s_d.st = CCR_ST_STOP;
               s_d.halt = 1'b1;
            end
         end
         CCR_ST_STOP: begin
            s_d.st = CCR_ST_MEAS;
            s_d.mstart = 1'b1;
         end
         CCR_ST_MEAS: begin
            if (meas_done) begin
               s_d.st = CCR_ST_IDLE;
               s_d.halt = 1'b0;
               s_d.vl_we = 1'b1;
               s_d.vl = meas_value;
               s_d.r4[CCR_B_VLIM_DET] = 1'b0;
            end
         end
         default: begin
            s_d.st = CCR_ST_IDLE;
            s_d.halt = 1'b0;
         end
      endcase
      // Watchdog restores its subset; register reset restores all.
      if (wdog_expire) begin
         s_d.r4 = restore(s_d.r4, rst4, CCR_WD_MASK_GATE);
         s_d.r5 = restore(s_d.r5, CCR_RST_SHIP_DSCH,
                          CCR_WD_MASK_SHIP);
      end
      if (reg_reset) begin
         s_d.r4 = rst4;
         s_d.r5 = CCR_RST_SHIP_DSCH;
         s_d.st = CCR_ST_IDLE;
         s_d.halt = 1'b0;
         s_d.mstart = 1'b0;
      end
      s_d.r4 = lock4(s_d.r4, s_d.a_ok, s_d.b_ok, gate_drive_master_off);
      s_d.r5 = lock5(s_d.r5);
      // Read data.
      case (req.addr)
         CCR_OFS_GATE_FREQ: s_d.rdata = s_d.r4;
         CCR_OFS_SHIP_DSCH: s_d.rdata = s_d.r5;
         default:           s_d.rdata = 8'h00;
      endcase
      if (!req.rd) begin
         s_d.rdata = s_q.rdata;
      end
      // Controls.
      s_d.ctl.gate_b_on        = s_d.r4[CCR_B_GATE_B];
      s_d.ctl.gate_a_on        = s_d.r4[CCR_B_GATE_A];
      s_d.ctl.rate_750k        = s_d.r4[CCR_B_SW_RATE];
      s_d.ctl.status_pin_off   = s_d.r4[CCR_B_STAT_OFF];
      s_d.ctl.short_hiccup_off = s_d.r4[CCR_B_SHORT_OFF];
      s_d.ctl.uv_hiccup_off    = s_d.r4[CCR_B_UV_OFF];
      s_d.ctl.in_ocp_on        = s_d.r4[CCR_B_IN_OCP];
      s_d.ctl.dsch_sense_on    = s_d.r5[CCR_B_DSCH_SENSE];
      s_d.ctl.dsch_lim_sel     = s_d.r5[CCR_B_DSCH_LIM +: 2];
      s_d.ctl.int_ilim_on      = s_d.r5[CCR_B_INT_ILIM];
      s_d.ctl.ext_ilim_on      = s_d.r5[CCR_B_EXT_ILIM];
      s_d.ctl.dsch_ocp_on      = s_d.r5[CCR_B_DSCH_OCP];
      s_d.ctl.ship_fitted      = s_d.r5[CCR_B_SHIP_FIT];
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.r4 <= CCR_RST_GATE_FREQ;
         s_q.r5 <= CCR_RST_SHIP_DSCH & ~CCR_SHIP_LOCK;
         s_q.ctl.in_ocp_on <= 1'b1;
         s_q.ctl.dsch_lim_sel <= CCR_DSCH_5A;
         s_q.ctl.int_ilim_on <= 1'b1;
         s_q.ctl.ext_ilim_on <= 1'b1;
         s_q.st <= CCR_ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops.
   assign rdata = s_q.rdata;
   assign ctl = s_q.ctl;
   assign switching_halt = s_q.halt;
   assign meas_start = s_q.mstart;
   assign input_voltage_limit_we = s_q.vl_we;
   assign input_voltage_limit = s_q.vl;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   // A gate pair found absent at start never has its driver enabled.
   chk_gate_b_lock: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      s_q.started && !s_q.b_ok |-> !ctl.gate_b_on)
      else $error("gate pair B enabled while absent");
   // The same lock holds for the first pair.
   chk_gate_a_lock: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      s_q.started && !s_q.a_ok |-> !ctl.gate_a_on)
      else $error("gate pair A enabled while absent");
   // A present pair follows the written enable unless overridden.
   chk_gate_a_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_GATE_FREQ && req.wdata[CCR_B_GATE_A] &&
      s_q.started && s_q.a_ok && !gate_drive_master_off && !reg_reset
      |=> ctl.gate_a_on)
      else $error("gate pair A not enabled by write");
   // The master switch clears both enables by the next cycle.
   chk_master_off: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      gate_drive_master_off |=> !ctl.gate_a_on && !ctl.gate_b_on)
      else $error("gate enable survived master off");
   // A rate write takes effect unless a register reset coincides.
   chk_rate_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_GATE_FREQ && !reg_reset
      |=> ctl.rate_750k == $past(req.wdata[CCR_B_SW_RATE]))
      else $error("rate bit does not follow write");
   // Register reset reloads the rate from the captured strap.
   chk_rate_strap: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      reg_reset |=> ctl.rate_750k == s_q.strap)
      else $error("rate bit not restored from strap");
   // Status pin control follows a write that no soft reset overrides.
   chk_status_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_GATE_FREQ && !reg_reset && !wdog_expire
      |=> ctl.status_pin_off == $past(req.wdata[CCR_B_STAT_OFF]))
      else $error("status pin control does not follow write");
   // Both hiccup disables follow a write.
   chk_hiccup_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_GATE_FREQ && !reg_reset
      |=> ctl.short_hiccup_off == $past(req.wdata[CCR_B_SHORT_OFF]) &&
      ctl.uv_hiccup_off == $past(req.wdata[CCR_B_UV_OFF]))
      else $error("hiccup disables do not follow write");
   // A detect request written with low battery is dropped.
   chk_det_refuse: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_GATE_FREQ && !batt_above_min_sys &&
      !s_q.r4[CCR_B_VLIM_DET] && !reg_reset |=> !s_q.r4[CCR_B_VLIM_DET])
      else $error("detect request accepted with low battery");
   // Halting is followed by the measurement start one cycle later.
   chk_det_seq: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $rose(switching_halt) && !reg_reset |=> meas_start)
      else $error("measurement did not follow halt");
   // The measurement start is a single-cycle pulse.
   chk_start_pulse: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      meas_start |=> !meas_start)
      else $error("measurement start longer than one cycle");
   // Completion drops the request and resumes switching.
   chk_det_clear: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      input_voltage_limit_we |-> !s_q.r4[CCR_B_VLIM_DET] && !switching_halt)
      else $error("request not cleared at completion");
   // The limit is only updated at the end of a halted measurement.
   chk_we_halted: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      input_voltage_limit_we |-> $past(switching_halt))
      else $error("limit updated without halt");
   // Input overcurrent enable follows a write.
   chk_ocp_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_GATE_FREQ && !reg_reset
      |=> ctl.in_ocp_on == $past(req.wdata[CCR_B_IN_OCP]))
      else $error("input overcurrent enable does not follow write");
   // Without the ship switch the discharge protection stays off.
   chk_ship_lock: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      !ctl.ship_fitted |-> !ctl.dsch_ocp_on)
      else $error("discharge protection on without ship switch");
   // Setting the fitted bit lets the locked bit be written in one go.
   chk_ship_unlock: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_SHIP_DSCH && req.wdata[CCR_B_SHIP_FIT] &&
      req.wdata[CCR_B_DSCH_OCP] && !reg_reset && !wdog_expire
      |=> ctl.ship_fitted && ctl.dsch_ocp_on)
      else $error("ship switch bits not writable once fitted");
   // Discharge sense, limit and internal limit follow a plain write.
   chk_dsch_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_SHIP_DSCH && !reg_reset && !wdog_expire
      |=> ctl.dsch_sense_on == $past(req.wdata[CCR_B_DSCH_SENSE]) &&
      ctl.dsch_lim_sel == $past(req.wdata[CCR_B_DSCH_LIM +: 2]) &&
      ctl.int_ilim_on == $past(req.wdata[CCR_B_INT_ILIM]))
      else $error("discharge controls do not follow write");
   // External limit enable follows a write; the watchdog leaves it.
   chk_ext_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.wr && req.addr == CCR_OFS_SHIP_DSCH && !reg_reset
      |=> ctl.ext_ilim_on == $past(req.wdata[CCR_B_EXT_ILIM]))
      else $error("external limit enable does not follow write");
   // The reserved bit always reads as zero.
   chk_rsvd_zero: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      req.rd && req.addr == CCR_OFS_SHIP_DSCH |=> !rdata[CCR_B_RSVD])
      else $error("reserved bit read as one");
   // Watchdog expiry restores its subset of fields.
   chk_wdog_rest: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      wdog_expire && !req.wr |=> ctl.int_ilim_on && !ctl.dsch_sense_on &&
      ctl.dsch_lim_sel == CCR_DSCH_5A && !ctl.status_pin_off)
      else $error("watchdog did not restore fields");
   // Watchdog expiry leaves the input overcurrent, external limit and hiccup fields, which only register reset restores.
   chk_wdog_keep: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      wdog_expire && !req.wr && !reg_reset |=> $stable(ctl.in_ocp_on) &&
      $stable(ctl.ext_ilim_on) && $stable(ctl.short_hiccup_off) &&
      $stable(ctl.uv_hiccup_off))
      else $error("watchdog changed a register-reset-only field");
   // Register reset restores the input overcurrent, external limit and both hiccup fields.
   chk_reg_reset: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      reg_reset |=> ctl.in_ocp_on && ctl.ext_ilim_on && !ctl.uv_hiccup_off
      && !ctl.short_hiccup_off)
      else $error("register reset did not restore fields");

endmodule

`default_nettype wire

// >>> include/ccr_pkg.sv
// Package for the charger control register pair (control 4 and control 5).
// Assumes a single 100 MHz clock domain and an 8-bit register access port.
`default_nettype none

package ccr_pkg;

   // ----------------------------------------------------------------------
   // Register offsets and bit positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] CCR_OFS_GATE_FREQ = 8'h13;
   localparam logic [7:0] CCR_OFS_SHIP_DSCH = 8'h14;

   localparam int CCR_B_GATE_B     = 7;
   localparam int CCR_B_GATE_A     = 6;
   localparam int CCR_B_SW_RATE    = 5;
   localparam int CCR_B_STAT_OFF   = 4;
   localparam int CCR_B_SHORT_OFF  = 3;
   localparam int CCR_B_UV_OFF     = 2;
   localparam int CCR_B_VLIM_DET   = 1;
   localparam int CCR_B_IN_OCP     = 0;

   localparam int CCR_B_SHIP_FIT   = 7;
   localparam int CCR_B_RSVD       = 6;
   localparam int CCR_B_DSCH_SENSE = 5;
   localparam int CCR_B_DSCH_LIM   = 3;
   localparam int CCR_B_INT_ILIM   = 2;
   localparam int CCR_B_EXT_ILIM   = 1;
   localparam int CCR_B_DSCH_OCP   = 0;

   // ----------------------------------------------------------------------
   // Reset values (bit 5 of control 4 comes from the strap instead)
   // ----------------------------------------------------------------------
   localparam logic [7:0] CCR_RST_GATE_FREQ = 8'h01;
   localparam logic [7:0] CCR_RST_SHIP_DSCH = 8'h16;
   // Fields restored by watchdog expiry as well as register reset.
   localparam logic [7:0] CCR_WD_MASK_GATE  = 8'h10;
   localparam logic [7:0] CCR_WD_MASK_SHIP  = 8'h3d;
   // Bit of control 5 that stays at zero until the ship switch is fitted.
   localparam logic [7:0] CCR_SHIP_LOCK     = 8'h01;

   // Discharge current limit codes.
   localparam logic [1:0] CCR_DSCH_3A  = 2'h0;
   localparam logic [1:0] CCR_DSCH_4A  = 2'h1;
   localparam logic [1:0] CCR_DSCH_5A  = 2'h2;
   localparam logic [1:0] CCR_DSCH_OFF = 2'h3;

   // ----------------------------------------------------------------------
   // Detection sequencer
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      CCR_ST_IDLE = 2'b00,
      CCR_ST_STOP = 2'b01,
      CCR_ST_MEAS = 2'b11
   } ccr_state_t;

   // Register access request from the serial front end.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccr_req_t;

   // Control outputs to the power stage.
   typedef struct packed {
      logic       gate_b_on;
      logic       gate_a_on;
      logic       rate_750k;
      logic       status_pin_off;
      logic       short_hiccup_off;
      logic       uv_hiccup_off;
      logic       in_ocp_on;
      logic       dsch_sense_on;
      logic [1:0] dsch_lim_sel;
      logic       int_ilim_on;
      logic       ext_ilim_on;
      logic       dsch_ocp_on;
      logic       ship_fitted;
   } ccr_ctl_t;

endpackage

`default_nettype wire

// >>> verif/ccr_meas_model.sv
// Behavioural model of the analog measurement path behind the registers.
// Assumes meas_start is a registered one-cycle pulse on ref_clk.
`default_nettype none

module ccr_meas_model #(
   parameter int         DLY   = 4,
   parameter logic [7:0] VALUE = 8'h5a
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Measurement handshake
   input  wire logic       meas_start,
   output var  logic       meas_done,
   output var  logic [7:0] meas_value
);
   timeunit 1ns;
   timeprecision 100ps;

   // Answers each start after DLY cycles; the value is only valid with done.
   initial begin
      meas_done  = 1'b0;
      meas_value = ~VALUE;
      forever begin
         @(posedge ref_clk);
         #1;
         if (nrst === 1'b1 && meas_start === 1'b1) begin
            repeat (DLY) @(posedge ref_clk);
            #1;
            meas_done  = 1'b1;
            meas_value = VALUE;
            @(posedge ref_clk);
            #1;
            meas_done  = 1'b0;
            meas_value = ~VALUE;
         end
      end
   end
endmodule

`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the charger control register pair.
// Assumes one 100 MHz clock and the measurement model beside the design.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ccr_pkg::*;

   localparam logic [7:0] MVAL = 8'h5a;
   logic       ref_clk;
   logic       nrst;
   ccr_req_t   req;
   logic [7:0] rdata;
   logic       reg_reset;
   logic       wdog_expire;
   logic       strap;
   logic       a_found;
   logic       b_found;
   logic       moff;
   logic       batt_ok;
   logic       meas_done;
   logic [7:0] meas_value;
   ccr_ctl_t   ctl;
   logic       halt;
   logic       meas_start;
   logic       lim_we;
   logic [7:0] lim;
   int         mismatches;
   int         checks_done;
   logic       seen_halt;
   logic       got;

   ccr_regs i_ccr_regs (.ref_clk(ref_clk), .nrst(nrst), .req(req),
      .rdata(rdata), .reg_reset(reg_reset), .wdog_expire(wdog_expire),
      .config_strap_pin(strap), .gate_pair_a_found(a_found),
      .gate_pair_b_found(b_found), .gate_drive_master_off(moff),
      .batt_above_min_sys(batt_ok), .meas_done(meas_done),
      .meas_value(meas_value), .ctl(ctl), .switching_halt(halt),
      .meas_start(meas_start), .input_voltage_limit_we(lim_we),
      .input_voltage_limit(lim));

   ccr_meas_model #(.DLY(4), .VALUE(MVAL)) i_ccr_meas_model (
      .ref_clk(ref_clk), .nrst(nrst), .meas_start(meas_start),
      .meas_done(meas_done), .meas_value(meas_value));

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   // Compares one value and counts the outcome.
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   // One register access; read data is settled when it returns.
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      req = '{wr: w, rd: ~w, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      req.wr = 1'b0;
      req.rd = 1'b0;
   endtask

   // Reads a register and compares the bits selected by the mask.
   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [7:0] e, input logic [7:0] m);
      acc(1'b0, a, 8'h00);
      chk(n, {8'h00, e & m}, {8'h00, rdata & m});
   endtask

   // Pulses the register reset (sel high) or the watchdog expiry.
   task automatic pulse(input logic sel);
      @(posedge ref_clk);
      #1;
      if (sel) reg_reset = 1'b1;
      else wdog_expire = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_reset   = 1'b0;
      wdog_expire = 1'b0;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock, watchdog and tests
   // ------------------------------------------------------------
   // Free running 100 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (5000) @(posedge ref_clk);
      mismatches++;
      end_of_test();
   end

   // Main sequence of register scenarios.
   initial begin
      mismatches = 0;
      checks_done = 0;
      nrst = 1'b0;
      req = '0;
      reg_reset = 1'b0;
      wdog_expire = 1'b0;
      strap = 1'b1;
      a_found = 1'b1;
      b_found = 1'b0;
      moff = 1'b0;
      batt_ok = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("ctl reset", 16'h08ac, 16'(ctl));
      rchk("ctl4 reset", 8'h13, 8'h21, 8'hff);
      rchk("ctl5 reset", 8'h14, 8'h16, 8'hff);
      rchk("unmapped", 8'h15, 8'h00, 8'hff);
      acc(1'b1, 8'h13, 8'he1);
      rchk("gate lock", 8'h13, 8'h61, 8'hff);
      chk("gate a", 16'h1, 16'(ctl.gate_a_on));
      moff = 1'b1;
      rchk("master off", 8'h13, 8'h21, 8'hff);
      chk("gate a off", 16'h0, 16'(ctl.gate_a_on));
      moff = 1'b0;
      acc(1'b1, 8'h13, 8'h3c);
      rchk("ctl4 write", 8'h13, 8'h3c, 8'hff);
      chk("ocp off", 16'h0, 16'(ctl.in_ocp_on));
      chk("ctl4 fields", 16'h0f2c, 16'(ctl));
      pulse(1'b0);
      rchk("ctl4 wdog", 8'h13, 8'h2c, 8'hff);
      pulse(1'b1);
      rchk("ctl4 regrst", 8'h13, 8'h21, 8'hff);
      acc(1'b1, 8'h14, 8'h7f);
      rchk("ship lock", 8'h14, 8'h3e, 8'hff);
      acc(1'b1, 8'h14, 8'hff);
      rchk("ship fit", 8'h14, 8'hbf, 8'hff);
      chk("dsch ocp", 16'h1, 16'(ctl.dsch_ocp_on));
      chk("ctl5 fields", 16'h08ff, 16'(ctl));
      pulse(1'b0);
      rchk("ctl5 wdog", 8'h14, 8'h96, 8'hff);
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, 8'h14, {3'b100, 2'(c), 3'b111});
         chk("dsch lim", 16'(c), 16'(ctl.dsch_lim_sel));
      end
      pulse(1'b1);
      rchk("ctl5 regrst", 8'h14, 8'h16, 8'hff);
      acc(1'b1, 8'h13, 8'h23);
      rchk("det refused", 8'h13, 8'h21, 8'hff);
      chk("no halt", 16'h0, 16'(halt));
      batt_ok = 1'b1;
      acc(1'b1, 8'h13, 8'h23);
      seen_halt = 1'b0;
      got = 1'b0;
      repeat (40) begin
         @(posedge ref_clk);
         #1;
         if (halt === 1'b1) seen_halt = 1'b1;
         if (lim_we === 1'b1 && !got) begin
            got = 1'b1;
            chk("limit", 16'(MVAL), 16'(lim));
         end
      end
      chk("halt seen", 16'h1, 16'(seen_halt));
      chk("limit we", 16'h1, 16'(got));
      chk("halt end", 16'h0, 16'(halt));
      rchk("det clear", 8'h13, 8'h21, 8'hff);
      end_of_test();
   end
endmodule

`default_nettype wire
